// File: logic/uiw_pkg.sv
// Package with register map, field layouts, reset values and timing for the UART interrupt block.
package uiw_pkg;
  // Avalon word addresses of the registers.
  localparam logic [2:0] UIW_ADDR_STATUS = 3'h0;
  localparam logic [2:0] UIW_ADDR_CTRL_ONE = 3'h1;
  localparam logic [2:0] UIW_ADDR_CTRL_TWO = 3'h2;
  localparam logic [2:0] UIW_ADDR_DATA = 3'h3;
  localparam logic [2:0] UIW_ADDR_BAUD = 3'h4;
  localparam logic [2:0] UIW_ADDR_INTC = 3'h5;

  // Field positions in the status word.
  localparam int UIW_ST_TX_EMPTY = 0;
  localparam int UIW_ST_TX_IDLE = 1;
  localparam int UIW_ST_RX_READY = 2;
  localparam int UIW_ST_OVERRUN = 3;
  localparam int UIW_ST_RX_BIT8 = 4;

  // Field positions in control register one.
  localparam int UIW_C1_NINE_BIT = 6;
  localparam int UIW_C1_PARITY_EN = 5;
  localparam int UIW_C1_UNIT_EN = 7;

  // Field positions in the interrupt control register.
  localparam int UIW_IC_GLOBAL = 0;
  localparam int UIW_IC_SERIAL = 1;

  // Reset values.
  localparam logic [7:0] UIW_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] UIW_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] UIW_BAUD_RST = 8'h00;
  localparam logic [1:0] UIW_INTC_RST = 2'h0;

  // Oscillator start-up time after an RX wake-up, and its count at 25 MHz.
  localparam int UIW_CLK_MHZ = 25;
  localparam int UIW_STARTUP_NS = 1000;
  localparam int UIW_STARTUP_CYC = (UIW_STARTUP_NS * UIW_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] UIW_STARTUP_LAST = 8'(UIW_STARTUP_CYC - 1);

  // Control register two, bit 7 down to bit 0.
  typedef struct packed {
    logic tx_empty_ie;
    logic tx_idle_ie;
    logic receiver_enable;
    logic addr_match_enable;
    logic wake_enable;
    logic rx_irq_enable;
    logic spare1;
    logic spare0;
  } uiw_ctrl_two_t;

  // Wake sequence states, Gray coded along run, sleep, start-up.
  typedef enum logic [1:0] {
    UIW_WK_RUN = 2'b00,
    UIW_WK_SLEEP = 2'b01,
    UIW_WK_START = 2'b11
  } uiw_wake_t;
endpackage : uiw_pkg

// File: logic/uiw_uart_irq.sv
// UART interrupt gathering, address detect qualifier and RX wake-up logic.
`timescale 1ns/1ns
// Notes on behaviour
// R1: Six interrupt sources: tx empty, tx idle, rx data, overrun, address, wake-up.
// R2: An enabled condition produces a one-cycle active-low interrupt pulse.
// R3: Vector only with global and UART enables set and stack not full.
// R4: Four flagged sources request only when their control-two enable is set.
// R5: Tx sources have own enables; rx data and overrun share one.
// R6: Address detect has no flag but interrupts when enabled and seen.
// R7: With clock off and all enables set, RX falling edge wakes.
// R8: Status flags are read only and survive interrupt entry.
// R9: With address enable set, rx data interrupts only if top bit is one.
// R10: Top bit is bit 8 in nine-bit mode, bit 7 otherwise.
// R11: A word whose top bit is one is an address word.
// R12: With address enable clear, every rx ready raises rx data interrupt.
// R13: Software must also set UART and global enables for address interrupts.
// R14: Software keeps parity disabled while address detect is on.
// R15: Transmission freezes while the UART clock is off.
// R16: Reception pauses while the UART clock is off.
// R17: Sleep leaves status, controls, data and baud registers unchanged.
// R18: Software should finish transfers before sleeping.
// R19: RX data during wake start-up is ignored.
// R20: Wake interrupt needs global and UART enables; else wake only.
// R21: Interrupt is held off until start-up time has elapsed.
// R22: Rx ready clears after status read then data read.
// R23: Overrun requests interrupt when the shared rx enable is set.
// R24: Request is OR of enabled qualified sources, while clock runs.
module uiw_uart_irq
  import uiw_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic fh_off_in,
  input wire logic stack_full_in,
  input wire logic tx_empty_in,
  input wire logic tx_idle_in,
  input wire logic rx_valid_in,
  input wire logic [8:0] rx_word_in,
  input wire logic rx_pin_in,
  output logic [7:0] ctrl_one_out,
  output uiw_ctrl_two_t ctrl_two_out,
  output logic [7:0] baud_divisor_out,
  output logic [7:0] tx_data_out,
  output logic tx_load_out,
  output logic serial_unit_clock_run_out,
  output logic rx_ignore_out,
  output logic wake_out,
  output logic irq_n_out,
  output logic irq_vector_out
);

  // Address bit selection by word length; used for the event and the latch.
  function automatic logic top_bit(input logic [8:0] word, input logic nine);
    top_bit = nine ? word[8] : word[7];
  endfunction : top_bit

  logic [7:0] uart_control_one_reg;
  uiw_ctrl_two_t uart_control_two_reg;
  logic [7:0] baud_divisor_reg;
  logic [1:0] intc_reg;
  logic [8:0] rx_data_reg;
  logic rx_top_reg;
  logic rx_data_ready_flag_reg;
  logic overrun_flag_reg;
  logic status_armed_reg;
  logic [7:0] tx_data_reg;
  logic tx_load_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;
  uiw_wake_t wk_state_reg;
  uiw_wake_t wk_state_next;
  logic [7:0] wk_cnt_reg;
  logic wake_reg;
  logic wake_pend_reg;
  logic req_prev_reg;
  logic irq_n_reg;
  logic vector_reg;

  // Bus decode; one wait state so the read word comes from a flop.
  // Nothing is taken while the clock enable is low, so a frozen bus simply waits.
  wire logic bus_req = avs_read_in | avs_write_in;
  wire logic bus_take = bus_req & ack_reg & ce_in;
  wire logic wr_take = bus_take & avs_write_in;
  wire logic rd_take = bus_take & avs_read_in;
  wire logic sel_status = avs_address_in == UIW_ADDR_STATUS;
  wire logic sel_ctrl_one = avs_address_in == UIW_ADDR_CTRL_ONE;
  wire logic sel_ctrl_two = avs_address_in == UIW_ADDR_CTRL_TWO;
  wire logic sel_data = avs_address_in == UIW_ADDR_DATA;
  wire logic sel_baud = avs_address_in == UIW_ADDR_BAUD;
  wire logic sel_intc = avs_address_in == UIW_ADDR_INTC;
  wire logic global_irq_enable = intc_reg[UIW_IC_GLOBAL];
  wire logic serial_irq_enable = intc_reg[UIW_IC_SERIAL];
  wire logic nine_bit_select = uart_control_one_reg[UIW_C1_NINE_BIT];
  wire logic serial_unit_enable = uart_control_one_reg[UIW_C1_UNIT_EN];

  // Status image; every field is hardware state, nothing software can set.
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[UIW_ST_TX_EMPTY] = tx_empty_in;
    status_word[UIW_ST_TX_IDLE] = tx_idle_in;
    status_word[UIW_ST_RX_READY] = rx_data_ready_flag_reg;
    status_word[UIW_ST_OVERRUN] = overrun_flag_reg;
    status_word[UIW_ST_RX_BIT8] = rx_data_reg[8];
  end
  wire logic [31:0] read_mux =
    sel_status ? status_word :
    sel_ctrl_one ? {24'h000000, uart_control_one_reg} :
    sel_ctrl_two ? {24'h000000, uart_control_two_reg} :
    sel_data ? {24'h000000, rx_data_reg[7:0]} :
    sel_baud ? {24'h000000, baud_divisor_reg} :
    sel_intc ? {30'h00000000, intc_reg} : 32'h00000000;

  // Bus handshake flops; frozen with the rest when the clock enable is low.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else if (ce_in) begin
      ack_reg <= bus_req & ~ack_reg;
      rdata_reg <= read_mux;
    end
  end

  // Writable registers; sleep has no path into them, so they keep their contents.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      uart_control_one_reg <= UIW_CTRL_ONE_RST;
      uart_control_two_reg <= UIW_CTRL_TWO_RST;
      baud_divisor_reg <= UIW_BAUD_RST;
      intc_reg <= UIW_INTC_RST;
      tx_data_reg <= 8'h00;
      tx_load_reg <= 1'b0;
    end else if (ce_in) begin
      tx_load_reg <= wr_take & sel_data; // see R17
      if (wr_take & sel_ctrl_one) uart_control_one_reg <= avs_writedata_in[7:0];
      if (wr_take & sel_ctrl_two) uart_control_two_reg <= avs_writedata_in[7:0];
      if (wr_take & sel_baud) baud_divisor_reg <= avs_writedata_in[7:0];
      if (wr_take & sel_intc) intc_reg <= avs_writedata_in[1:0];
      if (wr_take & sel_data) tx_data_reg <= avs_writedata_in[7:0];
    end
  end

  // Words arriving during wake start-up are dropped before they touch any flag.
  wire logic rx_accept = rx_valid_in & (wk_state_reg != UIW_WK_START); // see R19
  wire logic clear_seq = rd_take & sel_data & status_armed_reg; // see R22

  // Receive flags; a word arriving with the clearing read wins over the clear.
  // Single-entry buffer: a second word while ready is set only marks the overrun.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rx_data_reg <= 9'h000;
      rx_top_reg <= 1'b0;
      rx_data_ready_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
      status_armed_reg <= 1'b0;
    end else if (ce_in) begin
      if (rd_take & sel_status) status_armed_reg <= 1'b1;
      else if (rd_take & sel_data) status_armed_reg <= 1'b0;
      if (rx_accept & rx_data_ready_flag_reg & ~clear_seq) begin
        overrun_flag_reg <= 1'b1; // see R23
      end else if (clear_seq) begin
        overrun_flag_reg <= 1'b0; // see R8
      end
      if (rx_accept) begin
        rx_data_ready_flag_reg <= 1'b1;
      end else if (clear_seq) begin
        rx_data_ready_flag_reg <= 1'b0; // see R22
      end
      if (rx_accept & (~rx_data_ready_flag_reg | clear_seq)) begin
        rx_data_reg <= rx_word_in;
        rx_top_reg <= top_bit(rx_word_in, nine_bit_select); // see R10 see R11
      end
    end
  end

  // RX pin synchroniser; only the second flop and its delayed copy are read.
  // The flops reset to the idle mark level so no false fall follows a reset.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else if (ce_in) begin
      rx_meta_reg <= rx_pin_in;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  wire logic rx_fall = rx_prev_reg & ~rx_sync_reg;
  wire logic wake_armed = fh_off_in & serial_unit_enable & uart_control_two_reg.receiver_enable
    & uart_control_two_reg.rx_irq_enable & uart_control_two_reg.wake_enable; // see R7
  wire logic startup_done = wk_cnt_reg == UIW_STARTUP_LAST;
  wire logic wake_irq_ok = global_irq_enable & serial_irq_enable; // see R20

  // Wake sequence: sleep waits for an RX fall, start-up counts the oscillator time.
  // Leaving sleep when an enable drops keeps a stale arm from waking later.
  always_comb begin
    wk_state_next = wk_state_reg;
    case (wk_state_reg)
      UIW_WK_RUN: begin
        if (wake_armed) wk_state_next = UIW_WK_SLEEP;
      end
      UIW_WK_SLEEP: begin
        if (!wake_armed) wk_state_next = UIW_WK_RUN;
        else if (rx_fall) wk_state_next = UIW_WK_START; // see R7
      end
      UIW_WK_START: begin
        if (startup_done) wk_state_next = UIW_WK_RUN; // see R21
      end
      default: begin
        wk_state_next = UIW_WK_RUN;
      end
    endcase
  end

  // Wake state flops and the start-up counter.
  // The pending request lasts one cycle and is lost if the clock is still off then.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wk_state_reg <= UIW_WK_RUN;
      wk_cnt_reg <= 8'h00;
      wake_reg <= 1'b0;
      wake_pend_reg <= 1'b0;
    end else if (ce_in) begin
      wk_state_reg <= wk_state_next;
      wake_reg <= (wk_state_reg == UIW_WK_SLEEP) & (wk_state_next == UIW_WK_START);
      wk_cnt_reg <= (wk_state_reg == UIW_WK_START) ? wk_cnt_reg + 8'h01 : 8'h00;
      wake_pend_reg <= (wk_state_reg == UIW_WK_START) & startup_done & wake_irq_ok; // see R20
    end
  end

  // Interrupt sources; the address event itself carries no flag.
  wire logic clock_runs = ~fh_off_in & (wk_state_reg != UIW_WK_START); // see R21
  wire logic src_tx_empty = tx_empty_in & uart_control_two_reg.tx_empty_ie; // see R4 see R5
  wire logic src_tx_idle = tx_idle_in & uart_control_two_reg.tx_idle_ie; // see R5
  wire logic src_avail = rx_data_ready_flag_reg & uart_control_two_reg.rx_irq_enable
    & (~uart_control_two_reg.addr_match_enable | rx_top_reg); // see R9 see R12
  wire logic src_ovr = overrun_flag_reg & uart_control_two_reg.rx_irq_enable; // see R23
  wire logic src_addr = rx_accept & uart_control_two_reg.addr_match_enable
    & top_bit(rx_word_in, nine_bit_select); // see R6
  wire logic uart_req = clock_runs & (src_tx_empty | src_tx_idle | src_avail
    | src_ovr | src_addr | wake_pend_reg); // see R1 see R24
  wire logic vector_ok = global_irq_enable & serial_irq_enable & ~stack_full_in; // see R3

  // Request edge becomes a single low pulse; the vector follows the core gates.
  // A request that stays high interrupts once; uart_req must fall before it can pulse again.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      req_prev_reg <= 1'b0;
      irq_n_reg <= 1'b1;
      vector_reg <= 1'b0;
    end else if (ce_in) begin
      req_prev_reg <= uart_req;
      irq_n_reg <= ~(uart_req & ~req_prev_reg); // see R2
      vector_reg <= uart_req & ~req_prev_reg & vector_ok; // see R3
    end
  end

  // Outputs; the clock run flag pauses the shifters mid-word.
  assign avs_waitrequest_out = bus_req & ~(ack_reg & ce_in);
  assign avs_readdata_out = rdata_reg;
  assign ctrl_one_out = uart_control_one_reg;
  assign ctrl_two_out = uart_control_two_reg;
  assign baud_divisor_out = baud_divisor_reg;
  assign tx_data_out = tx_data_reg;
  assign tx_load_out = tx_load_reg;
  assign serial_unit_clock_run_out = ce_in & ~fh_off_in; // see R15 see R16
  assign rx_ignore_out = wk_state_reg == UIW_WK_START; // see R19
  assign wake_out = wake_reg;
  assign irq_n_out = irq_n_reg;
  assign irq_vector_out = vector_reg;

  // Checks on the design's own outputs and state.
  chk_irq_low_pulse: assert property (@(posedge mclk_in) disable iff (srst_in) // see R2
    (!irq_n_out && ce_in) |=> irq_n_out) else $error("irq low longer than one cycle");
  chk_vector_gates: assert property (@(posedge mclk_in) disable iff (srst_in) // see R3
    irq_vector_out |-> !irq_n_out && $past(vector_ok)) else $error("vector without gates");
  chk_status_readonly: assert property (@(posedge mclk_in) disable iff (srst_in) // see R8
    (wr_take && sel_status && !rx_accept && !clear_seq) |=> $stable(rx_data_ready_flag_reg)
    && $stable(overrun_flag_reg)) else $error("status changed by a write");
  chk_ready_clear_seq: assert property (@(posedge mclk_in) disable iff (srst_in) // see R22
    (rx_data_ready_flag_reg && rd_take && sel_data && !status_armed_reg) |=>
    rx_data_ready_flag_reg) else $error("ready cleared without status read");
  chk_addr_qualifier: assert property (@(posedge mclk_in) disable iff (srst_in) // see R9
    (uart_control_two_reg.addr_match_enable && !rx_top_reg && !src_tx_empty && !src_tx_idle
    && !src_ovr && !src_addr && !wake_pend_reg) |-> !uart_req)
    else $error("data word raised interrupt in address mode");
  chk_overrun_irq: assert property (@(posedge mclk_in) disable iff (srst_in) // see R23
    (overrun_flag_reg && uart_control_two_reg.rx_irq_enable && clock_runs) |-> uart_req)
    else $error("overrun did not request");
  chk_startup_hold: assert property (@(posedge mclk_in) disable iff (srst_in) // see R21
    (wk_state_reg == UIW_WK_START) |-> irq_n_out && rx_ignore_out)
    else $error("interrupt or data during start-up");
  chk_startup_length: assert property (@(posedge mclk_in) disable iff (srst_in) // see R21
    (wake_out && ce_in) |-> ##[0:30] (wk_state_reg == UIW_WK_RUN))
    else $error("start-up did not end");
  chk_wake_gate: assert property (@(posedge mclk_in) disable iff (srst_in) // see R20
    wake_pend_reg |-> $past(wake_irq_ok)) else $error("wake irq without enables");
  chk_freeze: assert property (@(posedge mclk_in) disable iff (srst_in) // see R15
    !ce_in |=> $stable(wk_state_reg) && $stable(rx_data_reg) && $stable(irq_n_out))
    else $error("state moved while frozen");
  chk_fall_wakes: assert property (@(posedge mclk_in) disable iff (srst_in) // see R7
    (wk_state_reg == UIW_WK_SLEEP && wake_armed && rx_fall && ce_in) |=> wake_out)
    else $error("RX fall did not wake");

  // Source gating, pulse origin and the start-up drop.
  chk_wake_armed: assert property (@(posedge mclk_in) disable iff (srst_in) // see R7
    (wake_out && $past(ce_in)) |-> $past(wake_armed)) else $error("wake while not armed");
  chk_avail_irq: assert property (@(posedge mclk_in) disable iff (srst_in) // see R12
    (rx_data_ready_flag_reg && uart_control_two_reg.rx_irq_enable && clock_runs
    && !uart_control_two_reg.addr_match_enable) |-> uart_req)
    else $error("ready flag did not request");
  chk_tx_masked: assert property (@(posedge mclk_in) disable iff (srst_in) // see R5
    (!uart_control_two_reg.tx_empty_ie && !uart_control_two_reg.tx_idle_ie && !src_avail
    && !src_ovr && !src_addr && !wake_pend_reg) |-> !uart_req)
    else $error("masked transmit source raised interrupt");
  chk_pulse_edge: assert property (@(posedge mclk_in) disable iff (srst_in) // see R24
    ($fell(irq_n_out) && $past(ce_in)) |-> $past(uart_req) && !$past(req_prev_reg))
    else $error("interrupt pulse without request edge");
  chk_ignore_drop: assert property (@(posedge mclk_in) disable iff (srst_in) // see R19
    (rx_ignore_out && rx_valid_in && ce_in && !clear_seq) |=> $stable(rx_data_reg)
    && $stable(overrun_flag_reg)) else $error("word taken during start-up");

  // Scenario covers.
  cov_wake_irq: cover property (@(posedge mclk_in) wake_out ##[1:40] !irq_n_out);
  cov_wake_masked: cover property (@(posedge mclk_in) wake_out && !wake_irq_ok);
  cov_overrun: cover property (@(posedge mclk_in) $rose(overrun_flag_reg));
  cov_addr_event: cover property (@(posedge mclk_in) src_addr ##1 !irq_n_reg);
  cov_clear_seq: cover property (@(posedge mclk_in) clear_seq && rx_data_ready_flag_reg);
endmodule : uiw_uart_irq

// File: verif/uiw_remote_peer.sv
// Behavioural model of the remote serial transmitter feeding the receive side.
`timescale 1ns/1ns
module uiw_remote_peer (
  input wire logic mclk_in,
  output logic rx_valid_out,
  output logic [8:0] rx_word_out,
  output logic rx_pin_out
);
  // The line idles at mark; with no word offered the word bus shows inverted junk.
  initial begin
    rx_valid_out = 1'h0;
    rx_word_out = 9'h1AA;
    rx_pin_out = 1'h1;
  end
  // Offer one received word for one cycle, then scramble the bus so stale data cannot match.
  task automatic send_word(input logic [8:0] w);
    @(posedge mclk_in);
    rx_valid_out <= 1'h1;
    rx_word_out <= w;
    @(posedge mclk_in);
    rx_valid_out <= 1'h0;
    rx_word_out <= ~w;
  endtask : send_word
  // A start bit gives the falling edge that wakes a sleeping receiver.
  task automatic start_bit();
    @(posedge mclk_in);
    rx_pin_out <= 1'h0;
    repeat (16) @(posedge mclk_in);
    rx_pin_out <= 1'h1;
  endtask : start_bit
endmodule : uiw_remote_peer

// File: verif/tb_uart_irq_addr_wakeup_logic.sv
// Self-checking testbench for the UART interrupt, address detect and wake-up block.
`timescale 1ns/1ns
module tb_uart_irq_addr_wakeup_logic
  import uiw_pkg::*;
;
  typedef struct packed {
    logic nine;
    logic aden;
    logic [8:0] word;
    logic irq;
  } uiw_row_t;
  // Receive cases: word length, address enable, received word, interrupt expected.
  uiw_row_t rows [8] = '{'{1'h0, 1'h0, 9'h000, 1'h1}, '{1'h0, 1'h0, 9'h080, 1'h1},
    '{1'h0, 1'h1, 9'h07F, 1'h0}, '{1'h0, 1'h1, 9'h080, 1'h1}, '{1'h1, 1'h1, 9'h0FF, 1'h0},
    '{1'h1, 1'h1, 9'h100, 1'h1}, '{1'h1, 1'h0, 9'h0FF, 1'h1}, '{1'h0, 1'h1, 9'h17F, 1'h0}};
  logic clk, rst, ce, rd, wr, fh, sf, te, ti, rv, rp, wt, tl, run, ign, wk, irqn, vec;
  logic [2:0] adr;
  logic [31:0] wd, rq, rd_q;
  logic [8:0] rw;
  logic [7:0] c1, bd, td;
  uiw_ctrl_two_t c2;
  int mismatches = 0, num_checks = 0, irq_cnt = 0, vec_cnt = 0, wk_cnt = 0, ld_cnt = 0;
  int i0, v0, w0, l0;

  uiw_uart_irq dut (.mclk_in(clk), .srst_in(rst), .ce_in(ce), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rq),
    .avs_waitrequest_out(wt), .fh_off_in(fh), .stack_full_in(sf), .tx_empty_in(te),
    .tx_idle_in(ti), .rx_valid_in(rv), .rx_word_in(rw), .rx_pin_in(rp), .ctrl_one_out(c1),
    .ctrl_two_out(c2), .baud_divisor_out(bd), .tx_data_out(td), .tx_load_out(tl),
    .serial_unit_clock_run_out(run), .rx_ignore_out(ign), .wake_out(wk), .irq_n_out(irqn),
    .irq_vector_out(vec));
  uiw_remote_peer peer (.mclk_in(clk), .rx_valid_out(rv), .rx_word_out(rw), .rx_pin_out(rp));

  // Clock at 25 MHz.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Pulses are counted with non-blocking updates so snapshots taken at an edge never race.
  always @(posedge clk) begin
    if (irqn === 1'h0) irq_cnt <= irq_cnt + 1;
    if (vec === 1'h1) vec_cnt <= vec_cnt + 1;
    if (wk === 1'h1) wk_cnt <= wk_cnt + 1;
    if (tl === 1'h1) ld_cnt <= ld_cnt + 1;
  end
  // The whole run needs about 400 cycles; 10000 means something hangs.
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask : chk
  // One Avalon access; the request holds until waitrequest is sampled low at an edge.
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'h0 && n < 200);
    rd_q = rq;
    if (n == 200) chk(32'h0, 32'h1, "bus timeout");
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : bus
  task automatic rdchk(input logic [2:0] a, input logic [31:0] exp, input string msg);
    bus(1'h0, a, 8'h00);
    chk(rd_q, exp, msg);
  endtask : rdchk
  // Status bit 4 is left out since it only mirrors bit 8 of the stored word.
  task automatic stchk(input logic [3:0] exp, input string msg);
    bus(1'h0, UIW_ADDR_STATUS, 8'h00);
    chk(32'(rd_q[3:0]), 32'(exp), msg);
  endtask : stchk
  task automatic snap();
    i0 = irq_cnt;
    v0 = vec_cnt;
    w0 = wk_cnt;
    l0 = ld_cnt;
  endtask : snap
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // Main sequence: reset and map checks, then the receive table, then the hand-written cases.
  initial begin
    {rst, ce, rd, wr, fh, sf, te, ti, adr, wd} = {2'h3, 6'h00, 3'h0, 32'h0};
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    chk(32'(irqn), 32'h1, "irq idle after reset");
    rdchk(UIW_ADDR_CTRL_TWO, 32'h0, "ctrl two reset");
    rdchk(UIW_ADDR_INTC, 32'h0, "intc reset");
    bus(1'h1, UIW_ADDR_STATUS, 8'hFF);
    stchk(4'h0, "status write ignored");
    bus(1'h1, 3'h6, 8'hFF);
    rdchk(3'h6, 32'h0, "unmapped read");
    bus(1'h1, UIW_ADDR_INTC, 8'h03);
    $display("test reset and map done");
    foreach (rows[k]) begin
      bus(1'h1, UIW_ADDR_CTRL_ONE, {1'h0, rows[k].nine, 6'h00});
      bus(1'h1, UIW_ADDR_CTRL_TWO, {3'h1, rows[k].aden, 4'h4});
      snap();
      peer.send_word(rows[k].word);
      repeat (4) @(posedge clk);
      chk(32'(irq_cnt != i0), 32'(rows[k].irq), "rx irq");
      chk(32'(vec_cnt != v0), 32'(rows[k].irq), "vector");
      stchk(4'h4, "ready set");
      rdchk(UIW_ADDR_DATA, {24'h0, rows[k].word[7:0]}, "rx data");
      stchk(4'h0, "ready cleared");
    end
    $display("test receive table done");
    // Each transmit source against its own enable and against the other one's.
    for (int k = 0; k < 4; k++) begin
      bus(1'h1, UIW_ADDR_CTRL_TWO, (k[0] ^ k[1]) ? 8'h40 : 8'h80);
      snap();
      te <= ~k[0];
      ti <= k[0];
      repeat (4) @(posedge clk);
      chk(32'(irq_cnt - i0), 32'(!k[1]), "tx irq pulse");
      stchk({2'h0, k[0], ~k[0]}, "tx flags");
      te <= 1'h0;
      ti <= 1'h0;
    end
    @(posedge clk);
    snap();
    sf <= 1'h1;
    te <= 1'h1;
    repeat (4) @(posedge clk);
    chk(32'(irq_cnt - i0), 32'h1, "irq with stack full");
    chk(32'(vec_cnt - v0), 32'h0, "no vector with stack full");
    {sf, te} <= 2'h0;
    $display("test transmit sources done");
    bus(1'h1, UIW_ADDR_CTRL_TWO, 8'h20);
    snap();
    peer.send_word(9'h011);
    peer.send_word(9'h022);
    repeat (3) @(posedge clk);
    chk(32'(irq_cnt - i0), 32'h0, "shared rx enable masks");
    stchk(4'hC, "overrun flag");
    rdchk(UIW_ADDR_DATA, 32'h11, "first word kept");
    stchk(4'h0, "overrun cleared");
    rdchk(UIW_ADDR_DATA, 32'h11, "data read disarms");
    peer.send_word(9'h033);
    rdchk(UIW_ADDR_DATA, 32'h33, "data read alone");
    stchk(4'h4, "ready kept without status read");
    rdchk(UIW_ADDR_DATA, 32'h33, "clear after status read");
    stchk(4'h0, "ready cleared by sequence");
    $display("test overrun done");
    bus(1'h1, UIW_ADDR_BAUD, 8'h5A);
    snap();
    bus(1'h1, UIW_ADDR_DATA, 8'hA5);
    repeat (2) @(posedge clk);
    chk(32'(ld_cnt - l0), 32'h1, "tx load pulse");
    fh <= 1'h1;
    @(posedge clk);
    chk(32'(run), 32'h0, "shifters paused");
    ce <= 1'h0;
    repeat (10) @(posedge clk);
    {ce, fh} <= 2'h2;
    @(posedge clk);
    chk(32'(run), 32'h1, "shifters resume");
    chk({16'h0, bd, td}, 32'h5AA5, "registers kept");
    rdchk(UIW_ADDR_CTRL_TWO, 32'h20, "ctrl two kept");
    $display("test clock stop done");
    bus(1'h1, UIW_ADDR_CTRL_ONE, 8'h80);
    bus(1'h1, UIW_ADDR_CTRL_TWO, 8'h2C);
    // Reception is idle here before the clock is stopped.
    for (int e = 1; e >= 0; e--) begin
      bus(1'h1, UIW_ADDR_INTC, {6'h00, e[0], e[0]});
      fh <= 1'h1;
      snap();
      peer.start_bit();
      chk(32'(wk_cnt - w0), 32'h1, "wake pulse");
      chk(32'(ign), 32'h1, "start-up ignores rx");
      chk(32'(irq_cnt - i0), 32'h0, "irq held in start-up");
      peer.send_word(9'h055);
      fh <= 1'h0;
      repeat (UIW_STARTUP_CYC - 10) @(posedge clk);
      chk(32'(irq_cnt - i0), 32'(e[0]), "wake irq gated");
      stchk(4'h0, "start-up word dropped");
    end
    $display("test wake-up done");
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdchk(UIW_ADDR_CTRL_ONE, 32'h0, "ctrl one after second reset");
    chk(32'(irqn), 32'h1, "irq idle after second reset");
    $display("test second reset done");
    finish_test();
  end
endmodule : tb_uart_irq_addr_wakeup_logic
